// File: src/adcsc_consts.svh
// Register indices, field positions, reset values and codes of the sequence controller
// What this block does
// - Single-channel mode repeats the coded channel
// - Multi-channel mode steps code upward, wrapping 7-0
// - Special mode converts internal reference sources
// - Internal sources yield FF, 00, 7F codes at 8 bits; 3FF, 000, 1FF at 10 bits
// - Channel code selects external input by value
// - In multi-channel mode without FIFO, result k holds channel start plus k
// - Single channel sequence: one, four or eight conversions
// - One-conversion length converts the specified channel once
// - Sequence end sets the sequence complete flag
// - Sequence flag clears on start, or on result read with fast clear
// - Status shows three-bit result slot counter
// - Slot counter zeroed per sequence unless FIFO
// - Conversion n sets complete flag n with result unless FIFO
// - Normal clear needs status read, then result access
// - Fast clear: result read clears its flag
// - Status one writes ignored except in test mode; status zero writes always ignored
// - Control four/five write clears all flags
// - Control four/five write aborts and restarts sequence
// - Length is four, one or eight conversions
// - Scan mode restarts identical sequence at once
`ifndef ADCSC_CONSTS_SVH
`define ADCSC_CONSTS_SVH

// Word indices; byte address is four times the index
`define ADCSC_IDX_CTL2 8'h62
`define ADCSC_IDX_CTL3 8'h63
`define ADCSC_IDX_CTL4 8'h64
`define ADCSC_IDX_CTL5 8'h65
`define ADCSC_IDX_STAT0 8'h66
`define ADCSC_IDX_STAT1 8'h67
`define ADCSC_IDX_RES_BASE 5'h0E

// Reset values
`define ADCSC_RST_CTL2 8'h00
`define ADCSC_RST_CTL3 8'h00
`define ADCSC_RST_CTL4 8'h01
`define ADCSC_RST_CTL5 8'h00

// Control field positions
`define ADCSC_BIT_FAST_CLR 0
`define ADCSC_BIT_TEST_MODE 7
`define ADCSC_BIT_FIFO 0
`define ADCSC_BIT_SINGLE 3
`define ADCSC_BIT_RES10 7
`define ADCSC_BIT_EIGHT 6
`define ADCSC_BIT_SCAN 5
`define ADCSC_BIT_MULTI 4
`define ADCSC_BIT_SPECIAL 3
`define ADCSC_BIT_SEQ_DONE 7

// Internal source codes and their expected results
`define ADCSC_SRC_HIGH 3'h4
`define ADCSC_SRC_LOW 3'h5
`define ADCSC_SRC_MID 3'h6
`define ADCSC_VAL_HIGH8 10'h0FF
`define ADCSC_VAL_HIGH10 10'h3FF
`define ADCSC_VAL_LOW 10'h000
`define ADCSC_VAL_MID8 10'h07F
`define ADCSC_VAL_MID10 10'h1FF

// Last conversion index per sequence length
`define ADCSC_LAST_ONE 3'h0
`define ADCSC_LAST_FOUR 3'h3
`define ADCSC_LAST_EIGHT 3'h7

`endif

// File: src/adcsc_pkg.sv
// Types shared by the sequence controller
`default_nettype none
package adcsc_pkg;
    typedef enum logic [0:0] {
        SEQ_IDLE,
        SEQ_CONV
    } adcsc_state_t;
endpackage
`default_nettype wire

// File: src/adcsc_top.sv
// Sequence controller of an 8-channel converter with APB registers and status flags
//
// Design decision made here: the APB register port.
`include "adcsc_consts.svh"
`default_nettype none
module adcsc_top (
    input wire logic sys_clk, // 100 MHz system clock
    input wire logic sys_rst, // Asynchronous reset, active high
    input wire logic psel, // APB select
    input wire logic penable, // APB enable
    input wire logic pwrite, // APB direction, high for write
    input wire logic [11:0] paddr, // APB byte address
    input wire logic [31:0] pwdata, // APB write data
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error on unmapped address
    output logic convStart, // Pulse: converter starts on convChan
    output logic [2:0] convChan, // External input to convert
    output logic convRes10, // Converter resolution, high for 10 bits
    input wire logic convDone, // Pulse: converter result valid
    input wire logic [9:0] convResult // Converter result, right justified
);

    // Bus phase decode
    logic setupPhase;
    logic accessPhase;
    logic [7:0] regIdx;
    logic alignedOk;
    logic isCtl2;
    logic isCtl3;
    logic isCtl4;
    logic isCtl5;
    logic isStat0;
    logic isStat1;
    logic isRes;
    logic mapped;
    logic wrAcc;
    logic rdAcc;
    logic [2:0] resSel;

    assign setupPhase = psel & ~penable;
    assign accessPhase = psel & penable;
    assign regIdx = paddr[9:2];
    assign alignedOk = (paddr[11:10] == 2'h0) && (paddr[1:0] == 2'h0);
    assign isCtl2 = alignedOk && (regIdx == `ADCSC_IDX_CTL2);
    assign isCtl3 = alignedOk && (regIdx == `ADCSC_IDX_CTL3);
    assign isCtl4 = alignedOk && (regIdx == `ADCSC_IDX_CTL4);
    assign isCtl5 = alignedOk && (regIdx == `ADCSC_IDX_CTL5);
    assign isStat0 = alignedOk && (regIdx == `ADCSC_IDX_STAT0);
    assign isStat1 = alignedOk && (regIdx == `ADCSC_IDX_STAT1);
    assign isRes = alignedOk && (regIdx[7:3] == `ADCSC_IDX_RES_BASE);
    assign resSel = regIdx[2:0];
    assign mapped = isCtl2 | isCtl3 | isCtl4 | isCtl5 | isStat0 | isStat1 | isRes;
    // Zero wait states: every access completes in its first access cycle
    assign pready = 1'b1;
    assign pslverr = accessPhase & ~mapped;
    assign wrAcc = accessPhase & pwrite & mapped;
    assign rdAcc = accessPhase & ~pwrite & mapped;

    // Control registers
    logic [7:0] ctl2_q;
    logic [7:0] ctl3_q;
    logic [7:0] ctl4_q;
    logic [7:0] ctl5_q;
    logic fastClr;
    logic testMode;
    logic fifoMode;
    logic singleSel;
    logic eightSel;
    logic scanSel;
    logic multiSel;
    logic specialSel;
    logic [2:0] chanCode;
    logic startSeq;

    assign fastClr = ctl2_q[`ADCSC_BIT_FAST_CLR];
    assign testMode = ctl2_q[`ADCSC_BIT_TEST_MODE];
    assign fifoMode = ctl3_q[`ADCSC_BIT_FIFO];
    assign singleSel = ctl3_q[`ADCSC_BIT_SINGLE];
    assign convRes10 = ctl4_q[`ADCSC_BIT_RES10];
    assign eightSel = ctl5_q[`ADCSC_BIT_EIGHT];
    assign scanSel = ctl5_q[`ADCSC_BIT_SCAN];
    assign multiSel = ctl5_q[`ADCSC_BIT_MULTI];
    assign specialSel = ctl5_q[`ADCSC_BIT_SPECIAL];
    assign chanCode = ctl5_q[2:0];
    // Writing either control four or five restarts everything
    assign startSeq = wrAcc & (isCtl4 | isCtl5);

    // Control register writes take effect at the access edge
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            ctl2_q <= `ADCSC_RST_CTL2;
            ctl3_q <= `ADCSC_RST_CTL3;
            ctl4_q <= `ADCSC_RST_CTL4;
            ctl5_q <= `ADCSC_RST_CTL5;
        end else begin
            if (wrAcc && isCtl2) begin
                ctl2_q <= pwdata[7:0];
            end
            if (wrAcc && isCtl3) begin
                ctl3_q <= pwdata[7:0];
            end
            if (wrAcc && isCtl4) begin
                ctl4_q <= pwdata[7:0];
            end
            if (wrAcc && isCtl5) begin
                ctl5_q <= pwdata[7:0];
            end
        end
    end

    // Sequencer state
    adcsc_pkg::adcsc_state_t state_q;
    logic [2:0] convIdx_q;
    logic [2:0] slot_q;
    logic launch_q;
    logic convStart_q;
    logic [2:0] convChan_q;
    logic [2:0] curCode;
    logic [2:0] lastIdx;
    logic inConv;
    logic doneEv;
    logic seqEnd;
    logic [9:0] specVal;
    logic [9:0] doneData;
    logic [2:0] slotAtStart;

    // Multi mode rotates the code; wraps naturally in three bits
    assign curCode = multiSel ? (chanCode + convIdx_q) : chanCode;
    // Eight wins over single; both clear gives four
    assign lastIdx = eightSel ? `ADCSC_LAST_EIGHT
                   : (singleSel ? `ADCSC_LAST_ONE : `ADCSC_LAST_FOUR);
    assign inConv = (state_q == adcsc_pkg::SEQ_CONV);
    // Internal sources finish in the launch cycle; external ones wait for the converter.
    // A done pulse in the cycle of a fresh start belongs to the aborted conversion.
    assign doneEv = inConv & ~startSeq
                  & (launch_q ? specialSel : (~convStart_q & convDone));
    assign seqEnd = doneEv & (convIdx_q == lastIdx);

    // Internal source results; reserved codes store zero
    assign specVal = (curCode == `ADCSC_SRC_HIGH)
                   ? (convRes10 ? `ADCSC_VAL_HIGH10 : `ADCSC_VAL_HIGH8)
                   : (curCode == `ADCSC_SRC_LOW) ? `ADCSC_VAL_LOW
                   : (curCode == `ADCSC_SRC_MID)
                   ? (convRes10 ? `ADCSC_VAL_MID10 : `ADCSC_VAL_MID8)
                   : 10'h000;
    assign doneData = specialSel ? specVal : convResult;
    // FIFO mode keeps filling from where the last sequence stopped
    assign slotAtStart = fifoMode ? slot_q : 3'h0;

    // Sequence progress: start has priority and aborts any conversion in flight
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_q <= adcsc_pkg::SEQ_IDLE;
            convIdx_q <= 3'h0;
            slot_q <= 3'h0;
            launch_q <= 1'b0;
        end else if (startSeq) begin
            state_q <= adcsc_pkg::SEQ_CONV;
            convIdx_q <= 3'h0;
            slot_q <= slotAtStart;
            launch_q <= 1'b1;
        end else begin
            launch_q <= 1'b0;
            case (state_q)
                adcsc_pkg::SEQ_IDLE: begin
                    launch_q <= 1'b0;
                end
                adcsc_pkg::SEQ_CONV: begin
                    if (doneEv) begin
                        slot_q <= slot_q + 3'h1;
                        launch_q <= 1'b1;
                        convIdx_q <= convIdx_q + 3'h1;
                        if (seqEnd) begin
                            convIdx_q <= 3'h0;
                            if (!scanSel) begin
                                state_q <= adcsc_pkg::SEQ_IDLE;
                                launch_q <= 1'b0;
                            end else if (!fifoMode) begin
                                slot_q <= 3'h0;
                            end
                        end
                    end
                end
                default: begin
                    state_q <= adcsc_pkg::SEQ_IDLE;
                end
            endcase
        end
    end

    // Converter request: registered so channel and strobe are stable together
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            convStart_q <= 1'b0;
            convChan_q <= 3'h0;
        end else begin
            convStart_q <= launch_q & inConv & ~specialSel & ~startSeq;
            if (launch_q) begin
                convChan_q <= curCode;
            end
        end
    end
    assign convStart = convStart_q;
    assign convChan = convChan_q;

    // Result storage, one word per slot
    logic [9:0] result_q [8];
    genvar k;
    generate
        for (k = 0; k < 8; k++) begin : g_res
            always_ff @(posedge sys_clk or posedge sys_rst) begin
                if (sys_rst) begin
                    result_q[k] <= 10'h000;
                end else if (doneEv && (slot_q == 3'(k))) begin
                    result_q[k] <= doneData;
                end
            end
        end
    endgenerate

    // Read data is captured in the setup cycle and held through the access
    logic [31:0] prdata_q;
    logic [31:0] readMux;
    logic seqDone_q;
    logic [7:0] doneFlags_q;
    logic [7:0] stat0Val;

    assign stat0Val = {seqDone_q, 4'h0, slot_q};
    assign readMux = isCtl2 ? {24'h0, ctl2_q}
                   : isCtl3 ? {24'h0, ctl3_q}
                   : isCtl4 ? {24'h0, ctl4_q}
                   : isCtl5 ? {24'h0, ctl5_q}
                   : isStat0 ? {24'h0, stat0Val}
                   : isStat1 ? {24'h0, doneFlags_q}
                   : isRes ? {22'h0, result_q[resSel]}
                   : 32'h0;

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            prdata_q <= 32'h0;
        end else if (setupPhase) begin
            prdata_q <= readMux;
        end
    end
    assign prdata = prdata_q;

    // Sequence complete flag: set wins over a fast clear in the same cycle
    logic seqDoneClr;
    assign seqDoneClr = startSeq | (fastClr & rdAcc & isRes);

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            seqDone_q <= 1'b0;
        end else if (seqEnd) begin
            seqDone_q <= 1'b1;
        end else if (seqDoneClr) begin
            seqDone_q <= 1'b0;
        end
    end

    // Per-flag logic. Arming records that the flag was seen set by a status read,
    // so only a flag software has actually observed can be cleared by normal mode.
    logic [7:0] armed_q;
    logic statRd;
    logic statTestWr;

    assign statRd = rdAcc & isStat1;
    // Status one writes only land in test mode; otherwise they are dropped silently
    assign statTestWr = wrAcc & isStat1 & testMode;

    generate
        for (k = 0; k < 8; k++) begin : g_flag
            logic setFlag;
            logic resHit;
            logic clrFlag;
            assign setFlag = doneEv & (slot_q == 3'(k));
            assign resHit = accessPhase & mapped & isRes & (resSel == 3'(k));
            assign clrFlag = startSeq
                           | (resHit & fastClr & ~pwrite)
                           | (resHit & ~fastClr & armed_q[k]);

            always_ff @(posedge sys_clk or posedge sys_rst) begin
                if (sys_rst) begin
                    doneFlags_q[k] <= 1'b0;
                end else if (setFlag) begin
                    doneFlags_q[k] <= 1'b1;
                end else if (statTestWr) begin
                    doneFlags_q[k] <= pwdata[k];
                end else if (clrFlag) begin
                    doneFlags_q[k] <= 1'b0;
                end
            end

            always_ff @(posedge sys_clk or posedge sys_rst) begin
                if (sys_rst) begin
                    armed_q[k] <= 1'b0;
                end else if (clrFlag | setFlag) begin
                    armed_q[k] <= 1'b0;
                end else if (statRd && prdata_q[k]) begin
                    armed_q[k] <= 1'b1;
                end
            end
        end
    endgenerate

endmodule
`default_nettype wire

// File: verif/adcsc_front_model.sv
// Converter front end model: answers each request after a set delay
`default_nettype none
module adcsc_front_model (
    input wire logic sys_clk, // System clock
    input wire logic sys_rst, // Reset, active high
    input wire logic convStart, // Request pulse
    input wire logic [2:0] convChan, // Channel to convert
    input wire logic [7:0] latency, // Delay of the answer
    output logic convDone, // Answer pulse
    output logic [9:0] convResult // Answer value
);
    timeunit 1ns;
    timeprecision 1ps;
    logic busy_q;
    logic [7:0] wait_q;
    logic [2:0] chan_q;
    // A new request drops the old one, so an aborted conversion answers only if its delay ends before the next request
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            busy_q <= 1'b0;
            convDone <= 1'b0;
            convResult <= 10'h000;
        end else begin
            convDone <= 1'b0;
            convResult <= ~convResult; // Garbage outside the pulse
            if (convStart) begin
                busy_q <= 1'b1;
                wait_q <= latency;
                chan_q <= convChan;
            end else if (busy_q && wait_q == 8'h00) begin
                busy_q <= 1'b0;
                convDone <= 1'b1;
                convResult <= {2'b00, 5'h14, chan_q}; // A0 plus channel
            end else if (busy_q) begin
                wait_q <= wait_q - 8'h01;
            end
        end
    end
endmodule
`default_nettype wire

// File: verif/adcsc_check_sva.sv
// Port checker of the sequence controller
`include "adcsc_consts.svh"
`default_nettype none
module adcsc_check (
    input wire logic sys_clk, // Clock
    input wire logic sys_rst, // Reset
    input wire logic psel, // Select
    input wire logic penable, // Enable
    input wire logic pwrite, // Direction
    input wire logic [11:0] paddr, // Address
    input wire logic [31:0] pwdata, // Write data
    input wire logic [31:0] prdata, // Read data
    input wire logic pready, // Ready
    input wire logic pslverr, // Error
    input wire logic convStart, // Request
    input wire logic [2:0] convChan, // Channel
    input wire logic convRes10, // Resolution
    input wire logic convDone, // Answer
    input wire logic [9:0] convResult // Value
);
    timeunit 1ns;
    timeprecision 1ps;
    // Shadow of the mode software last started
    localparam logic [11:0] ADDR_CTL3 = {2'b00, `ADCSC_IDX_CTL3, 2'b00};
    localparam logic [11:0] ADDR_CTL4 = {2'b00, `ADCSC_IDX_CTL4, 2'b00};
    localparam logic [11:0] ADDR_CTL5 = {2'b00, `ADCSC_IDX_CTL5, 2'b00};
    localparam logic [11:0] ADDR_STAT0 = {2'b00, `ADCSC_IDX_STAT0, 2'b00};
    logic [7:0] ctl5_q;
    logic [7:0] ctl3_q;
    logic [2:0] chan_q;
    logic [3:0] starts_q;
    logic armed_q;
    logic res10_q;
    wire logic wrAcc = psel && penable && pwrite && !pslverr;
    wire logic wrFive = wrAcc && paddr == ADDR_CTL5;
    wire logic wrFour = wrAcc && paddr == ADDR_CTL4;
    wire logic wrStart = wrFive || wrFour;
    wire logic toSpecial = wrFive ? pwdata[`ADCSC_BIT_SPECIAL] : ctl5_q[`ADCSC_BIT_SPECIAL];
    wire logic [3:0] seqLen = ctl5_q[6] ? 4'h8 : (ctl3_q[3] ? 4'h1 : 4'h4);
    // Expected channel and request count; scan restarts are not tracked
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            ctl5_q <= 8'h00;
            chan_q <= 3'h0;
            starts_q <= 4'h0;
            armed_q <= 1'b0;
        end else if (wrStart) begin
            ctl5_q <= wrFive ? pwdata[7:0] : ctl5_q;
            chan_q <= wrFive ? pwdata[2:0] : ctl5_q[2:0];
            starts_q <= 4'h0;
            armed_q <= 1'b1;
        end else if (convStart) begin
            chan_q <= chan_q + {2'b00, ctl5_q[4]}; // Steps only across channels
            starts_q <= starts_q + 4'h1;
        end
    end
    // Length select and resolution shadows
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            ctl3_q <= 8'h00;
            res10_q <= 1'b0;
        end else begin
            if (wrAcc && paddr == ADDR_CTL3) begin
                ctl3_q <= pwdata[7:0];
            end
            if (wrFour) begin
                res10_q <= pwdata[`ADCSC_BIT_RES10];
            end
        end
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    sequence launchReq;
        !convStart ##1 convStart;
    endsequence
    sequence scanDone;
        convDone && armed_q && ctl5_q[5] && !ctl5_q[3] && !wrStart;
    endsequence
    unmapped_error_a: assert property (psel && penable && paddr == 12'h000 |-> pslverr)
        else $error("no error on unmapped address");
    restart_on_write_a: assert property (wrStart && !toSpecial |=> launchReq)
        else $error("no request after start write");
    channel_order_a: assert property (
        convStart && !ctl5_q[3] && !(ctl5_q[4] && ctl5_q[5]) |-> convChan == chan_q)
        else $error("wrong channel requested");
    special_quiet_a: assert property (ctl5_q[3] && $past(ctl5_q[3], 2) |-> !convStart)
        else $error("request in internal source mode");
    idle_reset_a: assert property (!armed_q |-> !convStart)
        else $error("request before any start");
    seq_length_a: assert property (
        convStart && !ctl5_q[5] && !ctl5_q[3] |-> starts_q < seqLen)
        else $error("too many requests in sequence");
    scan_restart_a: assert property (scanDone |=> launchReq)
        else $error("scan did not continue");
    status_layout_a: assert property (
        psel && penable && !pwrite && paddr == ADDR_STAT0 |-> prdata[31:8] == 24'h000000
        && prdata[6:3] == 4'h0) else $error("status0 spare bits set");
    // Zero wait states: every access cycle must be answered at once
    ready_in_access_a: assert property (psel && penable |-> pready)
        else $error("access not answered at once");
    resolution_follow_a: assert property (convRes10 == res10_q)
        else $error("resolution differs from control four");
endmodule
bind adcsc_top adcsc_check u_check (.sys_clk(sys_clk), .sys_rst(sys_rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .convStart(convStart), .convChan(convChan),
    .convRes10(convRes10), .convDone(convDone), .convResult(convResult));
`default_nettype wire

// File: verif/test_adcsc_top.sv
// Bench: APB scenarios on the sequence controller with a converter model
`include "adcsc_consts.svh"
`default_nettype none
module test_adcsc_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [7:0] S0 = `ADCSC_IDX_STAT0;
    localparam logic [7:0] S1 = `ADCSC_IDX_STAT1;
    localparam logic [7:0] C5 = `ADCSC_IDX_CTL5;
    logic sys_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000;
    logic [7:0] latency = 8'h01;
    logic [31:0] prdata, rdData;
    logic pready, pslverr, errSeen, convStart, convRes10, convDone;
    logic [2:0] convChan;
    logic [9:0] convResult;
    int miscompares = 0;
    int tests_run = 0;
    adcsc_top uut (.sys_clk(sys_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .convStart(convStart), .convChan(convChan), .convRes10(convRes10),
        .convDone(convDone), .convResult(convResult));
    adcsc_front_model front (.sys_clk(sys_clk), .sys_rst(sys_rst), .convStart(convStart),
        .convChan(convChan), .latency(latency), .convDone(convDone), .convResult(convResult));
    // System clock, 10 ns period
    initial begin
        forever #5 sys_clk = ~sys_clk;
    end
    task automatic tally_and_finish();
        if (miscompares == 0 && tests_run > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] want);
        tests_run++;
        if (seen !== want) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", what, want, seen);
        end
    endtask
    // One APB transfer; request held until pready is seen high
    task automatic apb(input logic dir, input logic [7:0] idx, input logic [7:0] data);
        int n;
        n = 0;
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= dir;
        paddr <= {2'b00, idx, 2'b00};
        pwdata <= {24'h000000, data};
        @(posedge sys_clk);
        penable <= 1'b1;
        do begin
            @(posedge sys_clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            miscompares++;
            tally_and_finish();
        end
        rdData = prdata;
        errSeen = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rc(input string what, input logic [7:0] idx, input logic [31:0] want);
        apb(1'b0, idx, 8'h00);
        check(what, rdData, want);
    endtask
    // Polls a status bit; a bound keeps a dead sequence from hanging the run
    task automatic wait_flag(input logic [7:0] idx, input int bitNo);
        int n;
        n = 0;
        rdData = 32'h0;
        while (rdData[bitNo] !== 1'b1) begin
            apb(1'b0, idx, 8'h00);
            n++;
            if (n > 300) begin
                miscompares++;
                tally_and_finish();
            end
        end
    endtask
    function automatic logic [7:0] res(input int k);
        return {`ADCSC_IDX_RES_BASE, k[2:0]};
    endfunction
    function automatic logic [31:0] val(input int ch);
        return 32'hA0 + ch[2:0];
    endfunction
    // Scenario sequence
    initial begin
        repeat (12) @(posedge sys_clk);
        sys_rst <= 1'b0;
        rc("status0 reset", S0, 32'h0);
        rc("status1 reset", S1, 32'h0);
        apb(1'b0, 8'h00, 8'h00);
        check("unmapped error", {31'h0, errSeen}, 32'h1);
        apb(1'b1, C5, 8'h03);
        wait_flag(S0, 7);
        rc("status0 four", S0, 32'h84);
        rc("flags four", S1, 32'h0F);
        for (int k = 0; k < 4; k++) rc("single result", res(k), val(3));
        rc("flags read out", S1, 32'h0);
        // Slow converter, eight channels from 6, result read before the status read
        latency <= 8'h14;
        apb(1'b1, C5, 8'h56);
        wait_flag(S0, 7);
        rc("status0 eight", S0, 32'h80);
        rc("first result", res(0), val(6));
        rc("flags kept", S1, 32'hFF);
        for (int k = 0; k < 8; k++) rc("rotated result", res(k), val(6 + k));
        // Control four write after the first result aborts and restarts
        latency <= 8'h28;
        apb(1'b1, C5, 8'h02);
        wait_flag(S1, 0);
        apb(1'b1, `ADCSC_IDX_CTL4, 8'h01);
        rc("flags restart", S1, 32'h0);
        rc("status0 restart", S0, 32'h0);
        wait_flag(S0, 7);
        rc("restart flags", S1, 32'h0F);
        rc("restart result", res(3), val(2));
        // Fast clearing, one conversion
        latency <= 8'h01;
        apb(1'b1, `ADCSC_IDX_CTL2, 8'h01);
        apb(1'b1, `ADCSC_IDX_CTL3, 8'h08);
        apb(1'b1, C5, 8'h05);
        wait_flag(S0, 7);
        rc("status0 one", S0, 32'h81);
        rc("result one", res(0), val(5));
        rc("flags fast", S1, 32'h0);
        rc("status0 fast", S0, 32'h01);
        apb(1'b1, S0, 8'hFF);
        apb(1'b1, S1, 8'hFF);
        rc("status0 write", S0, 32'h01);
        rc("status1 write", S1, 32'h0);
        // Test mode is the one case where the flags take a write
        apb(1'b1, `ADCSC_IDX_CTL2, 8'h81);
        apb(1'b1, S1, 8'hA5);
        rc("status1 test write", S1, 32'hA5);
        apb(1'b1, `ADCSC_IDX_CTL2, 8'h01);
        apb(1'b1, `ADCSC_IDX_CTL3, 8'h09);
        apb(1'b1, C5, 8'h01);
        wait_flag(S0, 7);
        rc("status0 fifo", S0, 32'h82);
        rc("fifo result", res(1), val(1));
        // Internal sources over eight slots from code 4, then again at ten bits
        apb(1'b1, `ADCSC_IDX_CTL3, 8'h00);
        apb(1'b1, C5, 8'h5C);
        wait_flag(S0, 7);
        rc("internal flags", S1, 32'hFF);
        rc("internal high", res(0), 32'hFF);
        rc("internal low", res(1), 32'h00);
        rc("internal mid", res(2), 32'h7F);
        for (int k = 3; k < 8; k++) rc("internal reserved", res(k), 32'h0);
        apb(1'b1, `ADCSC_IDX_CTL4, 8'h81);
        wait_flag(S0, 7);
        check("resolution", {31'h0, convRes10}, 32'h1);
        rc("internal high ten", res(0), 32'h3FF);
        rc("internal mid ten", res(2), 32'h1FF);
        // Scan keeps going after the flag is cleared by a result read
        apb(1'b1, `ADCSC_IDX_CTL3, 8'h08);
        apb(1'b1, C5, 8'h27);
        wait_flag(S0, 7);
        rc("scan result", res(0), val(7));
        wait_flag(S0, 7);
        apb(1'b1, C5, 8'h07);
        tally_and_finish();
    end
endmodule
`default_nettype wire
